// file: logic/gmt_output_mux.sv
// module: general purpose output selection, pin arbitration and tune status
`timescale 1ns/1ps

// Overview of operation
// - selector picks pin signal while pin enabled
// - code 0 drives software test bit
// - codes 1-3 route lock detect signals
// - codes 8-11 route reference and divider clocks
// - codes 12-15 route auxiliary port signals
// - codes 16-19 route detector and modulator clocks
// - codes 20-25 route strobes and resets
// - code 30 buffer enable, 31 soft reset
// - automux between read data and aux signal
// - driver always on or only reads
// - high drive disable bit
// - low drive disable bit
// - read only switch setting from calibration
// - manual switch change leaves setting alone
// - busy flag high while calibration searches
module gmt_output_mux (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [gmt_pkg::AddrWidth-1:0] regAddr,
  input wire logic [gmt_pkg::RegWidth-1:0] regWrData,
  output logic [gmt_pkg::RegWidth-1:0] regRdData_q,
  input wire logic pinEnable,
  input wire logic serialRead,
  input wire logic serialBit,
  input wire gmt_pkg::gmt_src_s src,
  input wire logic calBusy,
  input wire logic [7:0] calSwitch,
  input wire logic manualSwitchWr,
  output logic auxPinSignal_q,
  output logic lockOrSerialOutPin_q,
  output logic lockOrSerialOutPinOeB_q
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  gmt_pkg::gmt_ctrl_s ctrl_q;
  logic [7:0] tuneSwitch_q;
  logic calBusy_q;
  logic busyFall;
  logic selWrite;
  logic [31:0] srcVec;

  assign selWrite = regWr && (regAddr == gmt_pkg::OutSelectAddr);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= gmt_pkg::OutSelectReset;
    end else if (ce && selWrite) begin
      ctrl_q <= regWrData[gmt_pkg::CtrlWidth-1:0];
    end
  end

  // ----------------------------------------------------------------
  // calibration status
  // ----------------------------------------------------------------
  // end of the search is the fall of the busy input
  assign busyFall = calBusy_q && !calBusy;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      calBusy_q <= gmt_pkg::TuneBusyReset;
    end else if (ce) begin
      calBusy_q <= calBusy;
    end
  end

  // capture calibrated setting
  // a manual switch write is deliberately not looked at here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tuneSwitch_q <= gmt_pkg::TuneSwitchReset;
    end else if (ce && busyFall) begin
      tuneSwitch_q <= calSwitch;
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  // read data is registered; unmapped offsets and reserved bits read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData_q <= '0;
    end else if (ce && regRd) begin
      case (regAddr)
        gmt_pkg::OutSelectAddr: begin
          regRdData_q <= {14'h0000, ctrl_q};
        end
        gmt_pkg::TuneStatusAddr: begin
          regRdData_q <= {15'h0000, calBusy_q, tuneSwitch_q};
        end
        default: begin
          regRdData_q <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // source vector, indexed by selector code
  // ----------------------------------------------------------------
  // code 0 is the test data bit
  assign srcVec[0] = ctrl_q.testData;
  assign srcVec[1] = src.lockDetect;
  assign srcVec[2] = src.lockTrigger;
  assign srcVec[3] = src.lockWindow;
  // analog test codes are served outside, reserved code 7 is low
  assign srcVec[7:4] = 4'h0;
  assign srcVec[8] = src.refBuffer;
  assign srcVec[9] = src.refDivider;
  assign srcVec[10] = src.vcoDivider;
  assign srcVec[11] = src.modulatorClk;
  assign srcVec[12] = src.auxClk;
  assign srcVec[13] = src.auxSerialClk;
  assign srcVec[14] = src.auxSerialEn;
  assign srcVec[15] = src.auxSerialData;
  assign srcVec[16] = src.phaseDetectorDown;
  assign srcVec[17] = src.phaseDetectorUp;
  assign srcVec[18] = src.sigmaDeltaCoreDelay;
  assign srcVec[19] = src.sigmaDeltaCoreClk;
  assign srcVec[20] = src.intWriteStrobe;
  assign srcVec[21] = src.fracWriteStrobe;
  assign srcVec[22] = src.auxWriteStrobe;
  assign srcVec[23] = src.serialLatchEn;
  assign srcVec[24] = src.vcoDivSyncReset;
  assign srcVec[25] = src.seedLoadStrobe;
  assign srcVec[29:26] = 4'h0;
  assign srcVec[30] = src.serialBufEn;
  assign srcVec[31] = src.softReset;

  // ----------------------------------------------------------------
  // selector and pin driver
  // ----------------------------------------------------------------
  // registered selection
  gmt_signal_mux #(
    .SelWidth(gmt_pkg::SelWidth)
  ) u_mux (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .sel(ctrl_q.outputSignalSelect),
    .srcVec(srcVec),
    .sigOut_q(auxPinSignal_q)
  );

  gmt_pin_driver u_drv (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .ctrl(ctrl_q),
    .pinEnable(pinEnable),
    .serialRead(serialRead),
    .serialBit(serialBit),
    .auxSignal(auxPinSignal_q),
    .pinOut_q(lockOrSerialOutPin_q),
    .pinOeB_q(lockOrSerialOutPinOeB_q)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // write lands in register
  ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && selWrite |=> ctrl_q == $past(regWrData[gmt_pkg::CtrlWidth-1:0]))
    else $error("control write not stored");

  test_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == gmt_pkg::SelTestData && !selWrite
    ##1 ce |=> auxPinSignal_q == $past(ctrl_q.testData))
    else $error("test data bit not selected");

  lock_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h01 |=> auxPinSignal_q == $past(src.lockDetect))
    else $error("lock detect not routed on code 1");

  div_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h0a |=> auxPinSignal_q == $past(src.vcoDivider))
    else $error("vco divider not routed on code 10");

  aux_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h0f |=> auxPinSignal_q == $past(src.auxSerialData))
    else $error("aux data not routed on code 15");

  det_up_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h11 |=> auxPinSignal_q == $past(src.phaseDetectorUp))
    else $error("detector up not routed on code 17");

  seed_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h19 |=> auxPinSignal_q == $past(src.seedLoadStrobe))
    else $error("seed strobe not routed on code 25");

  rst_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h1f |=> auxPinSignal_q == $past(src.softReset))
    else $error("soft reset not routed on code 31");

  trig_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h02 |=> auxPinSignal_q == $past(src.lockTrigger))
    else $error("lock trigger not routed on code 2");

  window_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h03 |=> auxPinSignal_q == $past(src.lockWindow))
    else $error("lock window not routed on code 3");

  refbuf_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h08 |=> auxPinSignal_q == $past(src.refBuffer))
    else $error("reference buffer not routed on code 8");

  refdiv_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h09 |=> auxPinSignal_q == $past(src.refDivider))
    else $error("reference divider not routed on code 9");

  modclk_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h0b |=> auxPinSignal_q == $past(src.modulatorClk))
    else $error("modulator clock not routed on code 11");

  auxclk_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h0c |=> auxPinSignal_q == $past(src.auxClk))
    else $error("aux clock not routed on code 12");

  auxsck_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h0d |=> auxPinSignal_q == $past(src.auxSerialClk))
    else $error("aux port clock not routed on code 13");

  auxen_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h0e |=> auxPinSignal_q == $past(src.auxSerialEn))
    else $error("aux port enable not routed on code 14");

  det_down_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h10 |=> auxPinSignal_q == $past(src.phaseDetectorDown))
    else $error("detector down not routed on code 16");

  core_delay_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h12 |=> auxPinSignal_q == $past(src.sigmaDeltaCoreDelay))
    else $error("core clock delay not routed on code 18");

  core_clk_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h13 |=> auxPinSignal_q == $past(src.sigmaDeltaCoreClk))
    else $error("core clock not routed on code 19");

  int_strobe_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h14 |=> auxPinSignal_q == $past(src.intWriteStrobe))
    else $error("integer strobe not routed on code 20");

  frac_strobe_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h15 |=> auxPinSignal_q == $past(src.fracWriteStrobe))
    else $error("fraction strobe not routed on code 21");

  aux_strobe_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h16 |=> auxPinSignal_q == $past(src.auxWriteStrobe))
    else $error("aux strobe not routed on code 22");

  latch_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h17 |=> auxPinSignal_q == $past(src.serialLatchEn))
    else $error("latch enable not routed on code 23");

  div_reset_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h18 |=> auxPinSignal_q == $past(src.vcoDivSyncReset))
    else $error("divider sync reset not routed on code 24");

  buf_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl_q.outputSignalSelect == 5'h1e |=> auxPinSignal_q == $past(src.serialBufEn))
    else $error("buffer enable not routed on code 30");

  unused_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && (ctrl_q.outputSignalSelect inside {[5'h04:5'h07], [5'h1a:5'h1d]}) |=> !auxPinSignal_q)
    else $error("unused selector code drove the pin signal");

  pin_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && !pinEnable && !serialRead |=> lockOrSerialOutPinOeB_q && !lockOrSerialOutPin_q)
    else $error("pin driven while disabled and idle");

  manual_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    manualSwitchWr && !busyFall |=> $stable(tuneSwitch_q))
    else $error("switch setting changed without calibration end");

  busy_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    calBusy_q && calBusy [*2] |-> $stable(tuneSwitch_q))
    else $error("switch setting changed during search");

  busy_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && calBusy_q && !calBusy |=> !calBusy_q && tuneSwitch_q == $past(calSwitch))
    else $error("switch setting not updated as busy cleared");

  busy_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && regRd && regAddr == gmt_pkg::TuneStatusAddr
    |=> regRdData_q[gmt_pkg::BusyBit] == $past(calBusy_q))
    else $error("busy flag read wrong");

  tune_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && regRd && regAddr == gmt_pkg::TuneStatusAddr
    |=> regRdData_q[7:0] == $past(tuneSwitch_q) && regRdData_q[23:9] == 15'h0000)
    else $error("tune status read wrong");

  // unmapped offsets read zero
  unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && regRd && regAddr != gmt_pkg::TuneStatusAddr && regAddr != gmt_pkg::OutSelectAddr
    |=> regRdData_q == 24'h000000)
    else $error("unmapped offset read non zero");

  // reads never disturb the control register
  read_side_a: assert property (@(posedge clk) disable iff (!rst_b)
    !selWrite |=> $stable(ctrl_q))
    else $error("control register changed without a write");

endmodule

// file: logic/gmt_pin_driver.sv
// module: automux, driver enable and half-driver control of the shared pin
`timescale 1ns/1ps
module gmt_pin_driver (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire gmt_pkg::gmt_ctrl_s ctrl,
  input wire logic pinEnable,
  input wire logic serialRead,
  input wire logic serialBit,
  input wire logic auxSignal,
  output logic pinOut_q,
  output logic pinOeB_q
);

  logic dataBit;
  logic driveOn;
  logic halfOff;

  assign dataBit = (serialRead && !ctrl.automuxPrevent) ? serialBit : (pinEnable & auxSignal);
  // driver always on or read only
  assign driveOn = serialRead || (pinEnable && ctrl.pinDriverAlwaysOn);
  assign halfOff = dataBit ? ctrl.highDriveOff : ctrl.lowDriveOff;

  // pin level and active low output enable, registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOut_q <= 1'b0;
      pinOeB_q <= 1'b1;
    end else if (ce) begin
      pinOut_q <= dataBit;
      pinOeB_q <= !(driveOn && !halfOff);
    end
  end

  high_drive_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl.highDriveOff |=> !(pinOut_q && !pinOeB_q))
    else $error("pin driven high while high drive disabled");
  low_drive_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl.lowDriveOff |=> !(!pinOut_q && !pinOeB_q))
    else $error("pin driven low while low drive disabled");
  driver_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && !ctrl.pinDriverAlwaysOn && !serialRead |=> pinOeB_q)
    else $error("pin driven outside a read cycle");
  automux_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && serialRead && !ctrl.automuxPrevent |=> pinOut_q == $past(serialBit))
    else $error("read data not on pin during read cycle");

endmodule

// file: logic/gmt_pkg.sv
// package: register map, field layout and carrier types of the output mux block
package gmt_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int AddrWidth = 5;
  localparam int RegWidth = 24;
  localparam logic [4:0] OutSelectAddr = 5'h0f;
  localparam logic [4:0] TuneStatusAddr = 5'h10;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CtrlWidth = 10;
  localparam int SelWidth = 5;
  localparam int BusyBit = 8;
  localparam logic [9:0] OutSelectReset = 10'h001;
  localparam logic [7:0] TuneSwitchReset = 8'h20;
  localparam logic TuneBusyReset = 1'b0;
  localparam logic [4:0] SelTestData = 5'h00;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  // control register fields, bit 9 down to bit 0
  typedef struct packed {
    logic lowDriveOff;
    logic highDriveOff;
    logic pinDriverAlwaysOn;
    logic automuxPrevent;
    logic testData;
    logic [4:0] outputSignalSelect;
  } gmt_ctrl_s;

  // internal signals that may be routed to the shared pin
  typedef struct packed {
    logic softReset;
    logic serialBufEn;
    logic seedLoadStrobe;
    logic vcoDivSyncReset;
    logic serialLatchEn;
    logic auxWriteStrobe;
    logic fracWriteStrobe;
    logic intWriteStrobe;
    logic sigmaDeltaCoreClk;
    logic sigmaDeltaCoreDelay;
    logic phaseDetectorUp;
    logic phaseDetectorDown;
    logic auxSerialData;
    logic auxSerialEn;
    logic auxSerialClk;
    logic auxClk;
    logic modulatorClk;
    logic vcoDivider;
    logic refDivider;
    logic refBuffer;
    logic lockWindow;
    logic lockTrigger;
    logic lockDetect;
  } gmt_src_s;

endpackage

// file: logic/gmt_signal_mux.sv
// module: registered one-of-n selector for the general purpose pin signal
`timescale 1ns/1ps
module gmt_signal_mux #(
  parameter int SelWidth = 5
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [SelWidth-1:0] sel,
  input wire logic [(1<<SelWidth)-1:0] srcVec,
  output logic sigOut_q
);

  logic picked;

  // pick the addressed source
  assign picked = srcVec[sel];

  // register the choice so glitches of the select never reach the pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sigOut_q <= 1'b0;
    end else if (ce) begin
      sigOut_q <= picked;
    end
  end

  // frozen while the enable is low
  hold_when_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(sigOut_q))
    else $error("selected signal changed while clock enable low");

endmodule

// file: tb/gmt_host_model.sv
// host side model: serial read driver, shared pin wire and tune status decode
`timescale 1ns/1ps
module gmt_host_model (
  input wire logic clk,
  input wire logic readReq,
  input wire logic readBit,
  input wire logic pinOut,
  input wire logic pinOeB,
  input wire logic [23:0] tuneWord,
  output logic serialRead,
  output logic serialBit,
  output logic pinLevel,
  output logic tuneValid,
  output logic [7:0] tuneSetting
);
  // switch bits that this subsystem really uses
  localparam logic [7:0] UsedMask = 8'hff;
  logic lastLevel;

  initial begin
    serialRead = 1'b0;
    serialBit = 1'b0;
    lastLevel = 1'b0;
  end

  // read cycle launched on the falling edge, away from the sampling edge; idle data line keeps toggling
  always @(negedge clk) begin
    serialRead <= readReq;
    serialBit <= readReq ? readBit : ~serialBit;
  end

  // released pin shows the inverse of the last driven level, no pull exists
  always @(posedge clk) begin
    if (pinOeB === 1'b0) begin
      lastLevel <= pinOut;
    end
  end
  assign pinLevel = (pinOeB === 1'b0) ? pinOut : ~lastLevel;

  assign tuneValid = (tuneWord[8] === 1'b0);
  assign tuneSetting = tuneWord[7:0] & UsedMask;
endmodule

// file: tb/tb.sv
// testbench: selector sweep, pin drive table, calibration status and reset
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [9:0] ctrl;
    logic pe;
    logic sr;
    logic sb;
    logic pin;
    logic oeB;
  } gmt_row_s;
  // control word, pin enable, read cycle, read bit, expected pin and enable
  localparam gmt_row_s Rows [10] = '{
    '{10'h0a0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0},
    '{10'h020, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1},
    '{10'h020, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
    '{10'h060, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0},
    '{10'h1a0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1},
    '{10'h180, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
    '{10'h280, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1},
    '{10'h2a0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0},
    '{10'h0a0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1},
    '{10'h020, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0}
  };
  logic clk, rst_b, ce, regWr, regRd, pinEnable, serialRead, serialBit, calBusy;
  logic manualSwitchWr, auxPinSignal_q, pin_q, oeB, readReq, readBit;
  logic pinLevel, tuneValid;
  logic [4:0] regAddr;
  logic [23:0] regWrData, regRdData_q;
  logic [7:0] calSwitch, tuneSetting;
  logic [22:0] hot;
  logic [9:0] ctrl;
  gmt_pkg::gmt_src_s src;
  int errTotal, checked, idx;

  gmt_output_mux i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData_q(regRdData_q),
    .pinEnable(pinEnable), .serialRead(serialRead), .serialBit(serialBit), .src(src),
    .calBusy(calBusy), .calSwitch(calSwitch), .manualSwitchWr(manualSwitchWr),
    .auxPinSignal_q(auxPinSignal_q), .lockOrSerialOutPin_q(pin_q),
    .lockOrSerialOutPinOeB_q(oeB));
  gmt_host_model i_host (.clk(clk), .readReq(readReq), .readBit(readBit), .pinOut(pin_q),
    .pinOeB(oeB), .tuneWord(regRdData_q), .serialRead(serialRead),
    .serialBit(serialBit), .pinLevel(pinLevel), .tuneValid(tuneValid),
    .tuneSetting(tuneSetting));

  // ----------------------------------------------------------------
  // clock, compare and closing
  // ----------------------------------------------------------------
  // free running clock, 5 ns period
  always #2.5 clk = ~clk;

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic endSim();
    $display("comparisons %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one write strobe, launched at the falling edge
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(negedge clk);
    regWr = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWr = 1'b0;
  endtask

  // one read strobe, data checked half a cycle after the taking edge
  task automatic rd(input logic [4:0] a, input logic [23:0] exp);
    @(negedge clk);
    regRd = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRd = 1'b0;
    chk("read data", regRdData_q, exp);
  endtask

  // watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #60000;
    errTotal++;
    endSim();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 5'h00;
    regWrData = 24'h000000;
    pinEnable = 1'b0;
    readReq = 1'b0;
    readBit = 1'b0;
    src = '0;
    calBusy = 1'b0;
    calSwitch = 8'h00;
    manualSwitchWr = 1'b0;
    errTotal = 0;
    checked = 0;
    repeat (2) @(negedge clk);
    chk("enable in reset", oeB, 1'b1);
    rst_b = 1'b1;
    rd(gmt_pkg::OutSelectAddr, 24'h000001);
    rd(gmt_pkg::TuneStatusAddr, 24'h000020);
    // refused writes and unmapped read
    wr(gmt_pkg::TuneStatusAddr, 24'h0001ff);
    rd(gmt_pkg::TuneStatusAddr, 24'h000020);
    wr(5'h03, 24'hffffff);
    rd(5'h11, 24'h000000);
    rd(gmt_pkg::OutSelectAddr, 24'h000001);
    pinEnable = 1'b1;
    for (int c = 0; c < 32; c++) begin
      if ((c >= 4 && c <= 7) || (c >= 26 && c <= 29)) continue;
      idx = (c <= 3) ? c - 1 : (c <= 25) ? c - 5 : c - 9;
      hot = (c == 0) ? 23'h000000 : (23'h000001 << idx);
      ctrl = 10'h080 | 10'(c) | ((c == 0) ? 10'h020 : 10'h000);
      wr(gmt_pkg::OutSelectAddr, {14'h3fff, ctrl});
      src = hot;
      repeat (4) @(negedge clk);
      chk("selected high", auxPinSignal_q, 1'b1);
      chk("pin high", pinLevel, 1'b1);
      rd(gmt_pkg::OutSelectAddr, {14'h0000, ctrl});
      wr(gmt_pkg::OutSelectAddr, {14'h0000, 10'h080 | 10'(c)});
      src = ~hot;
      repeat (4) @(negedge clk);
      chk("selected low", auxPinSignal_q, 1'b0);
    end
    // analog test code 5 is served outside this block and reads low here
    wr(gmt_pkg::OutSelectAddr, 24'h000085);
    src = '1;
    repeat (4) @(negedge clk);
    chk("code 5 low", auxPinSignal_q, 1'b0);
    src = '0;
    for (int i = 0; i < 10; i++) begin
      wr(gmt_pkg::OutSelectAddr, {14'h0000, Rows[i].ctrl});
      pinEnable = Rows[i].pe;
      readReq = Rows[i].sr;
      readBit = Rows[i].sb;
      repeat (5) @(negedge clk);
      chk("pin enable", oeB, Rows[i].oeB);
      if (Rows[i].oeB == 1'b0) chk("pin level", pinLevel, Rows[i].pin);
    end
    readReq = 1'b0;
    calBusy = 1'b1;
    calSwitch = 8'h5a;
    repeat (3) @(negedge clk);
    rd(gmt_pkg::TuneStatusAddr, 24'h000120);
    chk("setting valid", tuneValid, 1'b0);
    calSwitch = 8'hff;
    calBusy = 1'b0;
    rd(gmt_pkg::TuneStatusAddr, 24'h0000ff);
    chk("setting", tuneSetting, 8'hff);
    manualSwitchWr = 1'b1;
    calSwitch = 8'h00;
    repeat (2) @(negedge clk);
    manualSwitchWr = 1'b0;
    rd(gmt_pkg::TuneStatusAddr, 24'h0000ff);
    // reset in mid-run while the pin is driven
    wr(gmt_pkg::OutSelectAddr, 24'h0000a0);
    pinEnable = 1'b1;
    repeat (4) @(negedge clk);
    chk("driving", oeB, 1'b0);
    // clock enable low freezes every flop, register writes included
    ce = 1'b0;
    wr(gmt_pkg::OutSelectAddr, 24'h000000);
    pinEnable = 1'b0;
    repeat (2) @(negedge clk);
    chk("frozen enable", oeB, 1'b0);
    chk("frozen select", auxPinSignal_q, 1'b1);
    ce = 1'b1;
    pinEnable = 1'b1;
    rd(gmt_pkg::OutSelectAddr, 24'h0000a0);
    rst_b = 1'b0;
    #1;
    chk("enable in reset", oeB, 1'b1);
    chk("selected in reset", auxPinSignal_q, 1'b0);
    @(negedge clk);
    rst_b = 1'b1;
    rd(gmt_pkg::OutSelectAddr, 24'h000001);
    rd(gmt_pkg::TuneStatusAddr, 24'h000020);
    endSim();
  end
endmodule
